// ### i2c_slave_timeout.sv
// I2C slave with address match, byte transfer, clock hold and bus time-out.
// Contract
// - START is SDA falling while SCL high; set busy.
// - Shift seven address bits MSB first, compare own.
// - Address match sets flag and raises interrupt.
// - Eighth bit goes to read/write flag.
// - Matched address gets low acknowledge on ninth clock.
// - One interrupt for match, byte done, time-out.
// - Hold SCL low until data write or read.
// - Data bytes are eight bits, MSB first.
// - Receiver drives ack-to-send on ninth clock.
// - Transmitter on NACK releases SDA, awaits STOP.
// - Received bytes land in data register.
// - Time-out counts after match, cleared by SCL fall.
// - Period elapsing declares time-out; STOP halts counting.
// - Overflow stops counter, clears enable, sets flag.
// - Time-out resets slave and second control register.
// - Period is select plus one times 32.
// - Control holds enable, flag, select; flag clearable.
// - Byte-done clears during transfer, sets on completion.
// - STOP clears the bus busy flag.
// - Ninth-clock master acknowledge goes to received flag.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`include "i2c_slave_map.svh"

module i2c_slave_timeout #(
    parameter int SUB_DIV = `SUB_DIV_POR
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire i2c_slave_pkg::bus_addr_t  address_i,
    input  wire logic                      read_i,
    input  wire logic                      write_i,
    input  wire i2c_slave_pkg::bus_word_t  writedata_i,
    input  wire logic [3:0]                byteenable_i,
    output i2c_slave_pkg::bus_word_t       readdata_o,
    output wire logic                      waitrequest_o,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output wire logic                      scl_o,
    output wire logic                      scl_oe_o,
    output wire logic                      sda_o,
    output wire logic                      sda_oe_o,
    output logic                           irq_o
);
    import i2c_slave_pkg::*;

    localparam int DIV_W = $clog2(SUB_DIV);

    if (SUB_DIV < 2) begin : g_div_check
        $error("SUB_DIV must be at least 2");
    end

    function automatic logic [10:0] timeout_last(input logic [5:0] sel);
        return 11'((({5'h0, sel} + 11'd1) * 11'(`TO_UNIT_TICKS)) - 11'd1);
    endfunction

    logic         scl_s;
    logic         sda_s;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_det;
    logic         stop_det;
    logic         ack_q;
    logic         rd_take;
    logic         wr_take;
    logic [2:0]   function_select;
    logic         interface_enable;
    logic [6:0]   own_address_reg;
    logic         serial_irq_enable;
    logic [7:0]   serial_data_reg;
    logic         byte_done_flag;
    logic         addr_match_flag;
    logic         bus_busy_flag;
    logic         transmit_select;
    logic         ack_to_send;
    logic         read_write_flag;
    logic         ack_received_flag;
    logic         timeout_enable;
    logic         timeout_flag;
    logic [5:0]   timeout_select;
    slave_state_t state;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic         sda_drive;
    logic         scl_hold;
    logic [DIV_W-1:0] div_cnt;
    logic         sub_tick;
    logic         to_run;
    logic [10:0]  to_cnt;
    logic         to_over;
    logic         active;
    logic         addr_end;
    logic         addr_hit;
    logic         data_end;
    logic         release_go;

    i2c_line_sync u_sync (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .scl_o      (scl_s),
        .sda_o      (sda_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_det),
        .stop_o     (stop_det)
    );

    // Every access waits exactly one cycle so read data can come from a flop.
    assign waitrequest_o = (read_i | write_i) & ~ack_q;
    assign rd_take       = read_i & ack_q;
    assign wr_take       = write_i & ack_q & byteenable_i[0];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read_i | write_i) & ~ack_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            readdata_o <= '0;
        end else if (read_i & ~ack_q) begin
            case (address_i)
                `OFS_CTRL0:    readdata_o <= {24'h0, function_select, 3'h0,
                                              interface_enable, 1'b0};
                `OFS_CTRL1:    readdata_o <= {24'h0, byte_done_flag, addr_match_flag,
                                              bus_busy_flag, transmit_select, ack_to_send,
                                              read_write_flag, 1'b0, ack_received_flag};
                `OFS_DATA:     readdata_o <= {24'h0, serial_data_reg};
                `OFS_OWN_ADDR: readdata_o <= {24'h0, own_address_reg, 1'b0};
                `OFS_TIMEOUT:  readdata_o <= {24'h0, timeout_enable, timeout_flag,
                                              timeout_select};
                `OFS_IRQ_EN:   readdata_o <= {31'h0, serial_irq_enable};
                default:       readdata_o <= '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            function_select   <= `CTRL0_FSEL_POR;
            interface_enable  <= 1'b0;
            own_address_reg   <= 7'h00;
            serial_irq_enable <= 1'b0;
        end else if (wr_take) begin
            if (address_i == `OFS_CTRL0) begin
                function_select  <= writedata_i[`CTRL0_FSEL_HI:`CTRL0_FSEL_LO];
                interface_enable <= writedata_i[`CTRL0_ENABLE];
            end
            if (address_i == `OFS_OWN_ADDR) begin
                own_address_reg <= writedata_i[7:1];
            end
            if (address_i == `OFS_IRQ_EN) begin
                serial_irq_enable <= writedata_i[0];
            end
        end
    end

    assign active     = interface_enable && (function_select == `FSEL_I2C_SLAVE);
    assign addr_hit   = (shift[7:1] == own_address_reg);
    assign addr_end   = (state == st_addr) && scl_fall && (bit_cnt == 4'd8);
    assign data_end   = ((state == st_rx) || (state == st_tx)) && scl_fall
                        && (bit_cnt == 4'd8);
    assign release_go = (state == st_hold) && (address_i == `OFS_DATA)
                        && (transmit_select ? wr_take : rd_take);

    // A time-out or a disabled interface drops the slave back to idle at once.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !active || to_over) begin
            state     <= st_idle;
            bit_cnt   <= 4'd0;
            shift     <= 8'h00;
            sda_drive <= 1'b0;
            scl_hold  <= 1'b0;
        end else if (start_det) begin
            state     <= st_addr;
            bit_cnt   <= 4'd0;
            sda_drive <= 1'b0;
            scl_hold  <= 1'b0;
        end else if (stop_det) begin
            state     <= st_idle;
            sda_drive <= 1'b0;
            scl_hold  <= 1'b0;
        end else begin
            case (state)
                st_addr: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'd1;
                    end else if (addr_end) begin
                        bit_cnt <= 4'd0;
                        if (addr_hit) begin
                            state     <= st_addr_ack;
                            sda_drive <= 1'b1;
                        end else begin
                            state <= st_wait_stop;
                        end
                    end
                end
                st_addr_ack, st_rx_ack: begin
                    if (scl_fall) begin
                        sda_drive <= 1'b0;
                        scl_hold  <= 1'b1;
                        state     <= st_hold;
                    end
                end
                st_hold: begin
                    if (release_go) begin
                        scl_hold <= 1'b0;
                        bit_cnt  <= 4'd0;
                        if (transmit_select) begin
                            sda_drive <= ~writedata_i[7];
                            shift     <= {writedata_i[6:0], 1'b0};
                            state     <= st_tx;
                        end else begin
                            state <= st_rx;
                        end
                    end
                end
                st_rx: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'd1;
                    end else if (data_end) begin
                        sda_drive <= ~ack_to_send;
                        state     <= st_rx_ack;
                    end
                end
                st_tx: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'd1;
                    end else if (data_end) begin
                        sda_drive <= 1'b0;
                        state     <= st_tx_ack;
                    end else if (scl_fall) begin
                        sda_drive <= ~shift[7];
                        shift     <= {shift[6:0], 1'b0};
                    end
                end
                st_tx_ack: begin
                    if (scl_fall) begin
                        if (ack_received_flag) begin
                            state <= st_wait_stop;
                        end else begin
                            scl_hold <= 1'b1;
                            state    <= st_hold;
                        end
                    end
                end
                st_idle, st_wait_stop: begin
                    state <= state;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // The SDA and SCL outputs are tied low and only their drive enables change; both pins are open drain.
    assign sda_o    = 1'b0;
    assign scl_o    = 1'b0;
    assign sda_oe_o = sda_drive;
    assign scl_oe_o = scl_hold;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || to_over) begin
            transmit_select <= 1'b0;
            ack_to_send     <= 1'b0;
        end else if (wr_take && (address_i == `OFS_CTRL1)) begin
            transmit_select <= writedata_i[`CTRL1_TX_SEL];
            ack_to_send     <= writedata_i[`CTRL1_ACK_SEND];
        end
    end

    // Status flags go to their reset values whenever the interface is off.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !active || to_over) begin
            byte_done_flag    <= 1'b1;
            addr_match_flag   <= 1'b0;
            bus_busy_flag     <= 1'b0;
            read_write_flag   <= 1'b0;
            ack_received_flag <= 1'b1;
        end else begin
            if (start_det) begin
                bus_busy_flag   <= 1'b1;
                addr_match_flag <= 1'b0;
            end else if (stop_det) begin
                bus_busy_flag   <= 1'b0;
                addr_match_flag <= 1'b0;
            end else if (addr_end && addr_hit) begin
                addr_match_flag <= 1'b1;
                read_write_flag <= shift[0];
            end
            if (data_end) begin
                byte_done_flag <= 1'b1;
            end else if (release_go) begin
                byte_done_flag <= 1'b0;
            end
            if ((state == st_tx_ack) && scl_rise) begin
                ack_received_flag <= sda_s;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            serial_data_reg <= 8'h00;
        end else if ((state == st_rx) && data_end) begin
            serial_data_reg <= shift;
        end else if (wr_take && (address_i == `OFS_DATA)) begin
            serial_data_reg <= writedata_i[7:0];
        end
    end

    // The sub clock is only an enable pulse derived from the system clock.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || (div_cnt == DIV_W'(SUB_DIV - 1))) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign sub_tick = (div_cnt == DIV_W'(SUB_DIV - 1));
    assign to_over  = to_run && sub_tick && (to_cnt == timeout_last(timeout_select));

    // A flag set by an overflow wins over a clearing write in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            timeout_enable <= 1'b0;
            timeout_flag   <= 1'b0;
            timeout_select <= 6'h00;
        end else begin
            if (wr_take && (address_i == `OFS_TIMEOUT)) begin
                timeout_enable <= writedata_i[`TOC_ENABLE];
                timeout_flag   <= writedata_i[`TOC_FLAG];
                timeout_select <= writedata_i[`TOC_SEL_HI:`TOC_SEL_LO];
            end
            if (to_over) begin
                timeout_enable <= 1'b0;
                timeout_flag   <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || to_over || stop_det || !active || !timeout_enable) begin
            to_run <= 1'b0;
        end else if (addr_end && addr_hit) begin
            to_run <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !to_run || scl_fall) begin
            to_cnt <= 11'd0;
        end else if (sub_tick) begin
            to_cnt <= to_cnt + 11'd1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= serial_irq_enable && ((addr_end && addr_hit) || data_end || to_over);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence addr_byte_hit;
        addr_end && addr_hit && active && !start_det && !stop_det;
    endsequence

    sequence tx_nack_fall;
        (state == st_tx_ack) && scl_fall && ack_received_flag && active && !to_over
        && !start_det && !stop_det;
    endsequence

    start_busy_a: assert property (
        start_det && active && !to_over |=> bus_busy_flag && (state == st_addr))
        else $error("START did not set busy");
    stop_free_a: assert property (
        stop_det && !start_det && active |=> !bus_busy_flag && (state == st_idle))
        else $error("STOP did not free the bus");
    addr_match_a: assert property (
        addr_byte_hit and (serial_irq_enable && !to_over) |=> addr_match_flag && irq_o)
        else $error("Address match not flagged");
    rw_capture_a: assert property (
        addr_byte_hit and !to_over |=> read_write_flag == $past(shift[0]))
        else $error("Read/write bit not captured");
    addr_ack_a: assert property (
        addr_byte_hit and !to_over |=> sda_oe_o && (state == st_addr_ack))
        else $error("Address not acknowledged");
    mismatch_quiet_a: assert property (
        addr_end && !addr_hit && active && !start_det && !stop_det && !to_over
        |=> !sda_oe_o && !irq_o && (state == st_wait_stop))
        else $error("Mismatch was not ignored");
    hold_scl_a: assert property (
        (state == st_hold) && !release_go && active && !to_over && !start_det && !stop_det
        |=> scl_oe_o)
        else $error("SCL not held after match");
    rx_ack_a: assert property (
        (state == st_rx_ack) |-> sda_oe_o == !ack_to_send)
        else $error("Receive acknowledge level wrong");
    tx_nack_a: assert property (
        tx_nack_fall |=> !sda_oe_o && (state == st_wait_stop))
        else $error("SDA not released after NACK");
    rx_store_a: assert property (
        (state == st_rx) && data_end && !to_over |=> serial_data_reg == $past(shift)
        && byte_done_flag)
        else $error("Received byte not stored");
    scl_clears_a: assert property (
        to_run && scl_fall |=> to_cnt == 11'd0)
        else $error("SCL fall did not clear time-out count");
    timeout_hit_a: assert property (
        to_over |=> timeout_flag && !timeout_enable && !to_run && (state == st_idle)
        && byte_done_flag && ack_received_flag && !transmit_select)
        else $error("Time-out did not reset the slave");
endmodule

// ### i2c_slave_map.svh
// Register offsets, field positions, reset values and timing constants of the I2C slave.
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH

`define OFS_CTRL0       5'h00
`define OFS_CTRL1       5'h04
`define OFS_DATA        5'h08
`define OFS_OWN_ADDR    5'h0c
`define OFS_TIMEOUT     5'h10
`define OFS_IRQ_EN      5'h14

`define CTRL0_FSEL_HI   7
`define CTRL0_FSEL_LO   5
`define CTRL0_ENABLE    1
`define CTRL0_FSEL_POR  3'h7
`define FSEL_I2C_SLAVE  3'h6

`define CTRL1_BYTE_DONE 7
`define CTRL1_ADDR_HIT  6
`define CTRL1_BUSY      5
`define CTRL1_TX_SEL    4
`define CTRL1_ACK_SEND  3
`define CTRL1_RW        2
`define CTRL1_ACK_RX    0

`define TOC_ENABLE      7
`define TOC_FLAG        6
`define TOC_SEL_HI      5
`define TOC_SEL_LO      0

`define SYS_CLK_HZ      20000000
`define SUB_CLK_HZ      32768
`define SUB_DIV_POR     (`SYS_CLK_HZ / `SUB_CLK_HZ)
`define TO_UNIT_TICKS   32

`endif

// ### i2c_slave_pkg.sv
// Types shared by the I2C slave files.
package i2c_slave_pkg;
    typedef logic [31:0] bus_word_t;
    typedef logic [4:0]  bus_addr_t;
    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_hold,
        st_rx,
        st_rx_ack,
        st_tx,
        st_tx_ack,
        st_wait_stop
    } slave_state_t;
endpackage

// ### i2c_line_sync.sv
// Synchroniser and edge, START and STOP detector for the two bus lines.
module i2c_line_sync (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output wire logic scl_o,
    output wire logic sda_o,
    output wire logic scl_rise_o,
    output wire logic scl_fall_o,
    output wire logic start_o,
    output wire logic stop_o
);
    logic scl_ff1;
    logic scl_ff2;
    logic scl_q;
    logic sda_ff1;
    logic sda_ff2;
    logic sda_q;

    // The idle bus is high, so the chain resets to ones to avoid a false edge.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_ff1 <= 1'b1;
            scl_ff2 <= 1'b1;
            scl_q   <= 1'b1;
            sda_ff1 <= 1'b1;
            sda_ff2 <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            scl_ff1 <= scl_i;
            scl_ff2 <= scl_ff1;
            scl_q   <= scl_ff2;
            sda_ff1 <= sda_i;
            sda_ff2 <= sda_ff1;
            sda_q   <= sda_ff2;
        end
    end

    assign scl_o      = scl_ff2;
    assign sda_o      = sda_ff2;
    assign scl_rise_o = scl_ff2 & ~scl_q;
    assign scl_fall_o = ~scl_ff2 & scl_q;
    assign start_o    = scl_ff2 & scl_q & ~sda_ff2 & sda_q;
    assign stop_o     = scl_ff2 & scl_q & sda_ff2 & ~sda_q;
endmodule

// ### i2c_master_model.sv
// Behavioural I2C bus master that drives the far side of the slave.
module i2c_master_model (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_low_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int stuck = 0;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    // The slave may stretch SCL, so a release waits for the wire; the bound stops a hang.
    task automatic rel_scl();
        int n;
        n = 0;
        scl_low_o = 1'b0;
        while (scl_i !== 1'b1 && n < 4000) begin
            #10;
            n++;
        end
        if (n == 4000) stuck++;
    endtask
    task automatic start();
        #7 sda_low_o = 1'b0;
        rel_scl();
        #100 sda_low_o = 1'b1;
        #100 scl_low_o = 1'b1;
    endtask
    // Nine clocks, MSB first; a one is sent by releasing SDA to the pull-up.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #100 sda_low_o = ~tx[i];
            #100 rel_scl();
            #200 rx[i] = sda_i;
            scl_low_o = 1'b1;
        end
        #100 sda_low_o = 1'b0;
    endtask
    task automatic stop();
        #100 sda_low_o = 1'b1;
        #100 rel_scl();
        #100 sda_low_o = 1'b0;
        #100;
    endtask
endmodule

// ### i2c_slave_with_timeout_tb.sv
// Self-checking bench for the I2C slave with bus time-out.
`include "i2c_slave_map.svh"
module i2c_slave_with_timeout_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_slave_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    bus_addr_t adr = 5'h00;
    bus_word_t wdat = 32'h0;
    bus_word_t rdat;
    logic wreq, scl_oe, sda_oe, irq, m_scl, m_sda, scl_v, sda_v;
    wire logic scl_w = ~(m_scl | scl_oe);
    wire logic sda_w = ~(m_sda | sda_oe);
    int bad_count = 0;
    int checks_done = 0;
    int irqs = 0;
    logic [7:0] q;
    logic [8:0] rx;
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irqs++;
    i2c_slave_timeout #(.SUB_DIV(2)) dut (
        .ref_clk_i(clk), .rst_i(rst), .address_i(adr), .read_i(rd), .write_i(wr),
        .writedata_i(wdat), .byteenable_i(4'h1), .readdata_o(rdat), .waitrequest_o(wreq),
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_v), .scl_oe_o(scl_oe), .sda_o(sda_v),
        .sda_oe_o(sda_oe), .irq_o(irq));
    i2c_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // The request rises one edge after the call so a release and a new request never share a step.
    task automatic bus(input logic we, input bus_addr_t a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, d};
        wr <= we;
        rd <= ~we;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0) begin
            bad_count++;
            give_verdict();
        end else begin
            q = rdat[7:0];
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task automatic rg(input string s, input bus_addr_t a, input logic [7:0] k,
                      input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(s, e, q & k);
    endtask
    task automatic t_reset();
        rg("ctrl1", `OFS_CTRL1, 8'hff, 8'h81);
        rg("toc", `OFS_TIMEOUT, 8'hff, 8'h00);
        rg("unmapped", 5'h18, 8'hff, 8'h00);
        bus(1'b1, `OFS_CTRL0, 8'hc2);
        bus(1'b1, `OFS_OWN_ADDR, 8'h42);
        bus(1'b1, `OFS_IRQ_EN, 8'h01);
    endtask
    task automatic t_write();
        m.start();
        m.xfer(9'h085, rx);
        chk("addr ack", 8'h00, {7'h0, rx[0]});
        cyc(6);
        chk("hold", 8'h01, {7'h0, scl_oe});
        chk("pin lvl", 8'h00, {6'h0, scl_v, sda_v});
        chk("irq", 8'h01, 8'(irqs));
        rg("ctrl1", `OFS_CTRL1, 8'h64, 8'h60);
        bus(1'b0, `OFS_DATA, 8'h00);
        rg("byte busy", `OFS_CTRL1, 8'h80, 8'h00);
        m.xfer(9'h0b5, rx);
        chk("data ack", 8'h00, {7'h0, rx[0]});
        cyc(6);
        rg("ctrl1", `OFS_CTRL1, 8'he0, 8'he0);
        rg("data", `OFS_DATA, 8'hff, 8'h5a);
        bus(1'b1, `OFS_CTRL1, 8'h08);
        m.xfer(9'h079, rx);
        chk("nack", 8'h01, {7'h0, rx[0]});
        cyc(6);
        rg("data", `OFS_DATA, 8'hff, 8'h3c);
        chk("irq", 8'h03, 8'(irqs));
        m.stop();
        cyc(6);
        rg("busy", `OFS_CTRL1, 8'h20, 8'h00);
    endtask
    task automatic t_read();
        m.start();
        m.xfer(9'h087, rx);
        cyc(6);
        rg("ctrl1", `OFS_CTRL1, 8'h64, 8'h64);
        bus(1'b1, `OFS_CTRL1, 8'h10);
        bus(1'b1, `OFS_DATA, 8'ha5);
        m.xfer(9'h1fe, rx);
        chk("tx", 8'ha5, rx[8:1]);
        cyc(6);
        rg("ack rx", `OFS_CTRL1, 8'h01, 8'h00);
        bus(1'b1, `OFS_DATA, 8'h96);
        m.xfer(9'h1ff, rx);
        chk("tx", 8'h96, rx[8:1]);
        cyc(6);
        rg("ack rx", `OFS_CTRL1, 8'h01, 8'h01);
        chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
        m.stop();
    endtask
    task automatic t_miss();
        int n0;
        n0 = irqs;
        m.start();
        m.xfer(9'h089, rx);
        chk("no ack", 8'h01, {7'h0, rx[0]});
        m.stop();
        chk("irq", 8'(n0), 8'(irqs));
    endtask
    task automatic t_timeout();
        int n0;
        n0 = irqs;
        bus(1'b1, `OFS_TIMEOUT, 8'h81);
        m.start();
        m.xfer(9'h085, rx);
        cyc(100);
        chk("early", 8'(n0 + 1), 8'(irqs));
        cyc(60);
        chk("irq", 8'(n0 + 2), 8'(irqs));
        rg("toc", `OFS_TIMEOUT, 8'hff, 8'h41);
        rg("ctrl1", `OFS_CTRL1, 8'hff, 8'h81);
        rg("own", `OFS_OWN_ADDR, 8'hff, 8'h42);
        chk("hold", 8'h00, {7'h0, scl_oe});
        bus(1'b1, `OFS_TIMEOUT, 8'h01);
        rg("toc", `OFS_TIMEOUT, 8'hff, 8'h01);
        m.stop();
    endtask
    initial begin
        cyc(4);
        rst <= 1'b0;
        cyc(4);
        t_reset();
        t_write();
        t_read();
        t_miss();
        t_timeout();
        chk("stretch", 8'h00, 8'(m.stuck));
        give_verdict();
    end
endmodule
